// [design/bof_pkg.sv]
// Shared constants for the bit, flag and branch execution slice
package bof_pkg;

    // Operation codes presented by the instruction decoder
    localparam logic [4:0] OP_BRANCH_OVERFLOW_CLEAR = 5'h00;
    localparam logic [4:0] OP_BRANCH_IRQ_ENABLED = 5'h01;
    localparam logic [4:0] OP_BRANCH_IRQ_DISABLED = 5'h02;
    localparam logic [4:0] OP_IO_BIT_SET = 5'h03;
    localparam logic [4:0] OP_IO_BIT_CLEAR = 5'h04;
    localparam logic [4:0] OP_LOGICAL_LEFT_SHIFT = 5'h05;
    localparam logic [4:0] OP_LOGICAL_RIGHT_SHIFT = 5'h06;
    localparam logic [4:0] OP_ROTATE_LEFT_CARRY = 5'h07;
    localparam logic [4:0] OP_ROTATE_RIGHT_CARRY = 5'h08;
    localparam logic [4:0] OP_ARITH_RIGHT_SHIFT = 5'h09;
    localparam logic [4:0] OP_NIBBLE_SWAP = 5'h0A;
    localparam logic [4:0] OP_FLAG_INDEX_SET = 5'h0B;
    localparam logic [4:0] OP_FLAG_INDEX_CLEAR = 5'h0C;
    localparam logic [4:0] OP_BIT_TO_TRANSFER_FLAG = 5'h0D;
    localparam logic [4:0] OP_TRANSFER_FLAG_TO_BIT = 5'h0E;
    localparam logic [4:0] OP_CARRY_SET = 5'h0F;
    localparam logic [4:0] OP_CARRY_CLEAR = 5'h10;
    localparam logic [4:0] OP_NEGATIVE_SET = 5'h11;
    localparam logic [4:0] OP_NEGATIVE_CLEAR = 5'h12;
    localparam logic [4:0] OP_ZERO_FLAG_SET = 5'h13;
    localparam logic [4:0] OP_ZERO_FLAG_CLEAR = 5'h14;
    localparam logic [4:0] OP_GLOBAL_IRQ_ON = 5'h15;
    localparam logic [4:0] OP_GLOBAL_IRQ_OFF = 5'h16;
    localparam logic [4:0] OP_SIGN_FLAG_SET = 5'h17;
    localparam logic [4:0] OP_SIGN_FLAG_CLEAR = 5'h18;

    // Shift unit modes
    localparam logic [2:0] SH_SHL = 3'h0;
    localparam logic [2:0] SH_SHR = 3'h1;
    localparam logic [2:0] SH_RCL = 3'h2;
    localparam logic [2:0] SH_RCR = 3'h3;
    localparam logic [2:0] SH_SAR = 3'h4;

    // Bit positions inside the status register
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    // Register port offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_LAST_RESULT = 4'h1;
    localparam logic [3:0] REG_OP_COUNT = 4'h2;
    localparam logic [3:0] REG_ENGINE_STATE = 4'h3;

    // Values after reset
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Cycle counts of the multi-cycle operations
    localparam int unsigned BRANCH_TAKEN_CYCLES = 2;
    localparam int unsigned IO_BIT_CYCLES = 2;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BRANCH_HOLD = 3'b010,
        ST_IO_READ = 3'b100
    } bof_state_type;

endpackage : bof_pkg

// [design/bof_shift_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// Combinational shifter with flag generation
module bof_shift_unit
    import bof_pkg::*;
(
    input wire logic [2:0] mode,
    input wire logic [7:0] value,
    input wire logic carryIn,
    output logic [7:0] result,
    output logic carryOut,
    output logic zeroOut,
    output logic negOut,
    output logic ovfOut
);

    // Shift or rotate by one place, carry taken from the bit that falls out
    always_comb begin
        result = value;
        carryOut = carryIn;
        case (mode)
            SH_SHL: begin
                result = {value[6:0], 1'b0};
                carryOut = value[7];
            end
            SH_SHR: begin
                result = {1'b0, value[7:1]};
                carryOut = value[0];
            end
            SH_RCL: begin
                result = {value[6:0], carryIn};
                carryOut = value[7];
            end
            SH_RCR: begin
                result = {carryIn, value[7:1]};
                carryOut = value[0];
            end
            SH_SAR: begin
                result = {value[7], value[7:1]};
                carryOut = value[0];
            end
            default: begin
                result = value;
                carryOut = carryIn;
            end
        endcase
        // Overflow follows sign xor carry, as for every shift here
        zeroOut = (result == 8'h00);
        negOut = result[7];
        ovfOut = result[7] ^ carryOut;
    end

endmodule : bof_shift_unit
`default_nettype wire

// [design/bof_exec_unit.sv]
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Overflow clear branch: jump when overflow zero
// - Interrupts enabled branch: jump when I set
// - Interrupts disabled branch: jump when I clear
// - I/O bit set, two cycles, flags untouched
// - I/O bit clear, two cycles, flags untouched
// - Left shift, zero into bit 0
// - Right shift, zero into bit 7
// - Rotate left through carry, updates flags
// - Rotate right through carry, updates flags
// - Arithmetic right shift keeps bit 7
// - Register bit copied into transfer flag
// - Transfer flag copied into register bit
// - Sign flag set and clear, one cycle
module bof_exec_unit
    import bof_pkg::*;
#(
    parameter int unsigned PC_W = 16,
    parameter int unsigned IO_ADDR_W = 6
) (
    input wire logic clk_sys,
    input wire logic resetn,
    // Decoded operation from the decoder
    input wire logic opValid,
    input wire logic [4:0] opCode,
    input wire logic [2:0] opBitSel,
    input wire logic [6:0] opOffset,
    input wire logic [PC_W-1:0] pcIn,
    input wire logic [IO_ADDR_W-1:0] opIoAddr,
    input wire logic [4:0] opRegAddr,
    input wire logic [7:0] opRegValue,
    output logic opReady,
    // Program counter load
    output logic pcLoad,
    output logic [PC_W-1:0] pcTarget,
    // Working register write back
    output logic regWrEn,
    output logic [4:0] regWrAddr,
    output logic [7:0] regWrData,
    // I/O space access
    output logic ioRdEn,
    output logic ioWrEn,
    output logic [IO_ADDR_W-1:0] ioAddr,
    input wire logic [7:0] ioRdData,
    output logic [7:0] ioWrData,
    // Status register as seen by the rest of the core
    output logic [7:0] statusOut,
    // Software register port
    input wire logic [3:0] busAddr,
    input wire logic [7:0] busWrData,
    input wire logic busWrite,
    input wire logic busRead,
    output logic [7:0] busRdData
);

    // Sequencer state
    bof_state_type state_q;
    bof_state_type state_d;
    // Status register flags
    logic [7:0] status_q;
    logic [7:0] status_d;
    // Held I/O bit operation for the read-modify-write
    logic ioSetPending_q;
    logic [2:0] ioBit_q;
    // Last value written to a working register
    logic [7:0] lastResult_q;
    // Count of accepted operations, wraps
    logic [7:0] opCount_q;
    // Registered outputs
    logic opReady_q;
    logic pcLoad_q;
    logic [PC_W-1:0] pcTarget_q;
    logic regWrEn_q;
    logic [4:0] regWrAddr_q;
    logic [7:0] regWrData_q;
    logic ioRdEn_q;
    logic ioWrEn_q;
    logic [IO_ADDR_W-1:0] ioAddr_q;
    logic [7:0] ioWrData_q;
    logic [7:0] busRdData_q;
    // Decoded helpers
    logic accept;
    logic branchTaken;
    logic isBranch;
    logic isShift;
    logic [2:0] shiftMode;
    logic [7:0] shiftResult;
    logic shiftCarry;
    logic shiftZero;
    logic shiftNeg;
    logic shiftOvf;
    logic [7:0] statusBase;

    // Force one bit of a byte to a given value
    function automatic logic [7:0] putBit(input logic [7:0] value, input logic [2:0] pos, input logic bitVal);
        logic [7:0] mask;
        mask = 8'h01 << pos;
        putBit = bitVal ? (value | mask) : (value & ~mask);
    endfunction : putBit

    // Relative target: offset is signed two's complement, plus one word
    function automatic logic [PC_W-1:0] branchTarget(input logic [PC_W-1:0] pc, input logic [6:0] offs);
        logic [PC_W-1:0] extended;
        extended = {{(PC_W-7){offs[6]}}, offs};
        branchTarget = PC_W'(pc + extended + PC_W'(1));
    endfunction : branchTarget

    // A new operation is taken only when the sequencer has room
    assign accept = opValid && opReady_q;

    // Branch condition evaluation from the current flags
    always_comb begin
        isBranch = 1'b0;
        branchTaken = 1'b0;
        case (opCode)
            OP_BRANCH_OVERFLOW_CLEAR: begin
                isBranch = 1'b1;
                branchTaken = ~status_q[FLAG_V];
            end
            OP_BRANCH_IRQ_ENABLED: begin
                isBranch = 1'b1;
                branchTaken = status_q[FLAG_I];
            end
            OP_BRANCH_IRQ_DISABLED: begin
                isBranch = 1'b1;
                branchTaken = ~status_q[FLAG_I];
            end
            default: begin
                isBranch = 1'b0;
                branchTaken = 1'b0;
            end
        endcase
    end

    // Shift mode selection
    always_comb begin
        isShift = 1'b1;
        shiftMode = SH_SHL;
        case (opCode)
            OP_LOGICAL_LEFT_SHIFT: shiftMode = SH_SHL;
            OP_LOGICAL_RIGHT_SHIFT: shiftMode = SH_SHR;
            OP_ROTATE_LEFT_CARRY: shiftMode = SH_RCL;
            OP_ROTATE_RIGHT_CARRY: shiftMode = SH_RCR;
            OP_ARITH_RIGHT_SHIFT: shiftMode = SH_SAR;
            default: isShift = 1'b0;
        endcase
    end

    // Shared shifter, old carry feeds the rotates
    bof_shift_unit u_shift (
        .mode(shiftMode),
        .value(opRegValue),
        .carryIn(status_q[FLAG_C]),
        .result(shiftResult),
        .carryOut(shiftCarry),
        .zeroOut(shiftZero),
        .negOut(shiftNeg),
        .ovfOut(shiftOvf)
    );

    // Next status: a software write lands first, an instruction's own
    // flag update then overrides the bits it owns in the same cycle
    always_comb begin
        statusBase = (busWrite && busAddr == REG_STATUS) ? busWrData : status_q;
        status_d = statusBase;
        if (accept) begin
            if (isShift) begin
                status_d[FLAG_Z] = shiftZero;
                status_d[FLAG_C] = shiftCarry;
                status_d[FLAG_N] = shiftNeg;
                status_d[FLAG_V] = shiftOvf;
            end else begin
                case (opCode)
                    OP_FLAG_INDEX_SET: status_d = putBit(statusBase, opBitSel, 1'b1);
                    OP_FLAG_INDEX_CLEAR: status_d = putBit(statusBase, opBitSel, 1'b0);
                    OP_BIT_TO_TRANSFER_FLAG: status_d[FLAG_T] = opRegValue[opBitSel];
                    OP_CARRY_SET: status_d[FLAG_C] = 1'b1;
                    OP_CARRY_CLEAR: status_d[FLAG_C] = 1'b0;
                    OP_NEGATIVE_SET: status_d[FLAG_N] = 1'b1;
                    OP_NEGATIVE_CLEAR: status_d[FLAG_N] = 1'b0;
                    OP_ZERO_FLAG_SET: status_d[FLAG_Z] = 1'b1;
                    OP_ZERO_FLAG_CLEAR: status_d[FLAG_Z] = 1'b0;
                    OP_GLOBAL_IRQ_ON: status_d[FLAG_I] = 1'b1;
                    OP_GLOBAL_IRQ_OFF: status_d[FLAG_I] = 1'b0;
                    OP_SIGN_FLAG_SET: status_d[FLAG_S] = 1'b1;
                    OP_SIGN_FLAG_CLEAR: status_d[FLAG_S] = 1'b0;
                    // Branches, I/O bit ops, swap and bit load leave flags alone
                    default: status_d = statusBase;
                endcase
            end
        end
    end

    // Status register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (accept && isBranch && branchTaken) begin
                    state_d = ST_BRANCH_HOLD;
                end else if (accept && (opCode == OP_IO_BIT_SET || opCode == OP_IO_BIT_CLEAR)) begin
                    state_d = ST_IO_READ;
                end
            end
            // Second cycle of a taken branch, nothing else to do
            ST_BRANCH_HOLD: state_d = ST_IDLE;
            // Read data arrives now, the write goes out next cycle
            ST_IO_READ: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Ready is dropped for the extra cycle of two-cycle operations
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            opReady_q <= 1'b1;
        end else begin
            opReady_q <= (state_d == ST_IDLE);
        end
    end

    // Program counter load, one pulse on a taken branch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pcLoad_q <= 1'b0;
            pcTarget_q <= '0;
        end else begin
            pcLoad_q <= accept && isBranch && branchTaken;
            if (accept && isBranch && branchTaken) begin
                pcTarget_q <= branchTarget(pcIn, opOffset);
            end
        end
    end

    // I/O read-modify-write: read strobe first, then the write
    // The other bits are written back as read, so a register with
    // read-sensitive bits sees exactly one read and one write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ioRdEn_q <= 1'b0;
            ioWrEn_q <= 1'b0;
            ioAddr_q <= '0;
            ioWrData_q <= 8'h00;
            ioSetPending_q <= 1'b0;
            ioBit_q <= 3'h0;
        end else begin
            ioRdEn_q <= 1'b0;
            ioWrEn_q <= 1'b0;
            if (accept && (opCode == OP_IO_BIT_SET || opCode == OP_IO_BIT_CLEAR)) begin
                ioRdEn_q <= 1'b1;
                ioAddr_q <= opIoAddr;
                ioBit_q <= opBitSel;
                ioSetPending_q <= (opCode == OP_IO_BIT_SET);
            end
            if (state_q == ST_IO_READ) begin
                ioWrEn_q <= 1'b1;
                ioWrData_q <= putBit(ioRdData, ioBit_q, ioSetPending_q);
            end
        end
    end

    // Working register write back for shifts, swap and bit load
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            regWrEn_q <= 1'b0;
            regWrAddr_q <= 5'h00;
            regWrData_q <= 8'h00;
        end else begin
            regWrEn_q <= 1'b0;
            if (accept && isShift) begin
                regWrEn_q <= 1'b1;
                regWrAddr_q <= opRegAddr;
                regWrData_q <= shiftResult;
            end else if (accept && opCode == OP_NIBBLE_SWAP) begin
                regWrEn_q <= 1'b1;
                regWrAddr_q <= opRegAddr;
                regWrData_q <= {opRegValue[3:0], opRegValue[7:4]};
            end else if (accept && opCode == OP_TRANSFER_FLAG_TO_BIT) begin
                regWrEn_q <= 1'b1;
                regWrAddr_q <= opRegAddr;
                regWrData_q <= putBit(opRegValue, opBitSel, status_q[FLAG_T]);
            end
        end
    end

    // Last result and operation counter, visible to software
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lastResult_q <= RESULT_RESET;
            opCount_q <= COUNT_RESET;
        end else begin
            if (regWrEn_q) begin
                lastResult_q <= regWrData_q;
            end
            if (accept) begin
                opCount_q <= 8'(opCount_q + 8'h01);
            end
        end
    end

    // Register read port, data stands the cycle after the strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busRdData_q <= 8'h00;
        end else begin
            busRdData_q <= 8'h00;
            if (busRead) begin
                if (busAddr == REG_STATUS) begin
                    busRdData_q <= status_q;
                end else if (busAddr == REG_LAST_RESULT) begin
                    busRdData_q <= lastResult_q;
                end else if (busAddr == REG_OP_COUNT) begin
                    busRdData_q <= opCount_q;
                end else if (busAddr == REG_ENGINE_STATE) begin
                    busRdData_q <= {5'h00, state_q};
                end else begin
                    // Unmapped offsets read as zero
                    busRdData_q <= 8'h00;
                end
            end
        end
    end

    // Outputs straight from flip-flops
    assign opReady = opReady_q;
    assign pcLoad = pcLoad_q;
    assign pcTarget = pcTarget_q;
    assign regWrEn = regWrEn_q;
    assign regWrAddr = regWrAddr_q;
    assign regWrData = regWrData_q;
    assign ioRdEn = ioRdEn_q;
    assign ioWrEn = ioWrEn_q;
    assign ioAddr = ioAddr_q;
    assign ioWrData = ioWrData_q;
    assign statusOut = status_q;
    assign busRdData = busRdData_q;

endmodule : bof_exec_unit
`default_nettype wire

// [sim/bof_exec_unit_props.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the slice
module bof_exec_props
    import bof_pkg::*;
#(
    parameter int unsigned PC_W = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic opValid,
    input wire logic [4:0] opCode,
    input wire logic [2:0] opBitSel,
    input wire logic [6:0] opOffset,
    input wire logic [PC_W-1:0] pcIn,
    input wire logic [7:0] opRegValue,
    input wire logic opReady,
    input wire logic pcLoad,
    input wire logic [PC_W-1:0] pcTarget,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic ioRdEn,
    input wire logic ioWrEn,
    input wire logic [7:0] ioRdData,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] statusOut,
    input wire logic busRead,
    input wire logic [7:0] busRdData
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Operation handed over
    logic acc;
    assign acc = opValid && opReady;
    // Previous-cycle snapshots
    logic [7:0] valQ;
    logic [7:0] stQ;
    logic [7:0] rdQ;
    logic [2:0] selQ;
    logic setQ;
    logic shQ;
    logic [PC_W-1:0] tgtQ;

    // Tie each result to its cause
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            valQ <= 8'h00;
            stQ <= 8'h00;
            rdQ <= 8'h00;
            selQ <= 3'h0;
            setQ <= 1'b0;
            shQ <= 1'b0;
            tgtQ <= '0;
        end else begin
            valQ <= opRegValue;
            stQ <= statusOut;
            tgtQ <= pcIn + {{(PC_W-7){opOffset[6]}}, opOffset} + 1'b1;
            shQ <= acc && opCode >= OP_LOGICAL_LEFT_SHIFT && opCode <= OP_ARITH_RIGHT_SHIFT;
            // Held to the next accept
            if (acc) begin
                selQ <= opBitSel;
                setQ <= (opCode == OP_IO_BIT_SET);
            end
            if (ioRdEn) begin
                rdQ <= ioRdData;
            end
        end
    end

    a_vclr_taken: assert property (acc && opCode == OP_BRANCH_OVERFLOW_CLEAR && !statusOut[FLAG_V]
        |=> pcLoad && pcTarget == tgtQ && !opReady) else $error("branch not taken");
    a_vclr_skip: assert property (acc && opCode == OP_BRANCH_OVERFLOW_CLEAR && statusOut[FLAG_V]
        |=> !pcLoad && opReady) else $error("branch taken wrongly");
    a_irq_on_jump: assert property (acc && opCode == OP_BRANCH_IRQ_ENABLED
        |=> pcLoad == stQ[FLAG_I] && statusOut == stQ) else $error("irq-on branch");
    a_irq_off_jump: assert property (acc && opCode == OP_BRANCH_IRQ_DISABLED
        |=> pcLoad == !stQ[FLAG_I] && statusOut == stQ) else $error("irq-off branch");
    a_io_two_cycle: assert property (acc && (opCode == OP_IO_BIT_SET || opCode == OP_IO_BIT_CLEAR)
        |=> ioRdEn && !ioWrEn && !opReady ##1 ioWrEn && opReady && statusOut == stQ) else $error("io bit sequence");
    a_io_bit_data: assert property (ioWrEn
        |-> ioWrData == (setQ ? (rdQ | (8'h01 << selQ)) : (rdQ & ~(8'h01 << selQ)))) else $error("io write data");
    a_shift_flags: assert property (shQ |-> regWrEn && statusOut[FLAG_N] == regWrData[7]
        && statusOut[FLAG_V] == (statusOut[FLAG_N] ^ statusOut[FLAG_C])
        && statusOut[FLAG_Z] == (regWrData == 8'h00)) else $error("shift flags");
    a_shl_result: assert property (acc && opCode == OP_LOGICAL_LEFT_SHIFT
        |=> regWrData == {valQ[6:0], 1'b0} && statusOut[FLAG_C] == valQ[7]) else $error("left shift");
    a_swap_nibbles: assert property (acc && opCode == OP_NIBBLE_SWAP
        |=> regWrData == {valQ[3:0], valQ[7:4]} && statusOut == stQ) else $error("nibble swap");
    a_sign_set: assert property (acc && opCode == OP_SIGN_FLAG_SET
        |=> statusOut == (stQ | 8'h10)) else $error("sign set");
    a_tflag_copy: assert property (acc && opCode == OP_BIT_TO_TRANSFER_FLAG
        |=> statusOut[FLAG_T] == valQ[selQ] && (statusOut & 8'hBF) == (stQ & 8'hBF))
        else $error("transfer flag store");
    a_pc_pulse: assert property (pcLoad |=> !pcLoad && opReady) else $error("pc load pulse");
    a_bus_quiet: assert property (!busRead |=> busRdData == 8'h00) else $error("stray read data");
endmodule : bof_exec_props

bind bof_exec_unit bof_exec_props #(.PC_W(PC_W)) i_props (
    .clk_sys(clk_sys), .resetn(resetn), .opValid(opValid), .opCode(opCode),
    .opBitSel(opBitSel), .opOffset(opOffset), .pcIn(pcIn), .opRegValue(opRegValue),
    .opReady(opReady), .pcLoad(pcLoad), .pcTarget(pcTarget), .regWrEn(regWrEn),
    .regWrData(regWrData), .ioRdEn(ioRdEn), .ioWrEn(ioWrEn), .ioRdData(ioRdData),
    .ioWrData(ioWrData), .statusOut(statusOut), .busRead(busRead), .busRdData(busRdData)
);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Bench with a status and result model
module tb
    import bof_pkg::*;
;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic opValid = 1'b0;
    logic [4:0] opCode = 5'h00;
    logic [2:0] opBitSel = 3'h0;
    logic [6:0] opOffset = 7'h00;
    logic [15:0] pcIn = 16'h0000;
    logic [5:0] opIoAddr = 6'h00;
    logic [4:0] opRegAddr = 5'h00;
    logic [7:0] opRegValue = 8'h00;
    logic [7:0] ioRdData = 8'h00;
    logic [3:0] busAddr = 4'h0;
    logic [7:0] busWrData = 8'h00;
    logic busWrite = 1'b0;
    logic busRead = 1'b0;
    logic opReady, pcLoad, regWrEn, ioRdEn, ioWrEn;
    logic [15:0] pcTarget;
    logic [4:0] regWrAddr;
    logic [5:0] ioAddr;
    logic [7:0] regWrData, ioWrData, statusOut, busRdData;
    logic [7:0] ms = 8'h00; // Model status register
    logic [7:0] lr = 8'h00; // Model last result
    int opCount = 0;
    int seed = 91390;
    int fail_count = 0;
    int check_count = 0;
    int fl[5] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S}; // Dedicated flag forms in opcode order

    bof_exec_unit i_dut (
        .clk_sys, .resetn, .opValid, .opCode, .opBitSel, .opOffset, .pcIn, .opIoAddr, .opRegAddr, .opRegValue,
        .opReady, .pcLoad, .pcTarget, .regWrEn, .regWrAddr, .regWrData, .ioRdEn, .ioWrEn, .ioAddr, .ioRdData,
        .ioWrData, .statusOut, .busAddr, .busWrData, .busWrite, .busRead, .busRdData
    );

    // 40 MHz core clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Four-state exact compare
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // One-cycle register write
    task automatic bw(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busAddr <= a;
        busWrData <= d;
        busWrite <= 1'b1;
        @(posedge clk_sys);
        busWrite <= 1'b0;
        if (a == REG_STATUS) begin
            ms = d;
        end
    endtask : bw

    // Register read, data in the next cycle
    task automatic br(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge clk_sys);
        busRead <= 1'b0;
        #1;
        chk("busRdData", busRdData, e);
    endtask : br

    // One operation, random operands
    task automatic ex(input logic [4:0] op);
        logic [7:0] v, r, iv, m;
        logic [6:0] k;
        logic [15:0] pc, tgt;
        logic [2:0] b;
        logic c, tk, wr, io;
        int f;
        v = $random(seed);
        iv = $random(seed);
        k = $random(seed);
        pc = $random(seed);
        b = $random(seed);
        r = v;
        c = 1'b0;
        tk = 1'b0;
        m = 8'h01 << b;
        tgt = pc + {{9{k[6]}}, k} + 16'h0001;
        io = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR);
        wr = (op >= OP_LOGICAL_LEFT_SHIFT && op <= OP_NIBBLE_SWAP) || op == OP_TRANSFER_FLAG_TO_BIT;
        // Model; unknown codes do nothing
        case (op)
            OP_BRANCH_OVERFLOW_CLEAR: tk = !ms[FLAG_V];
            OP_BRANCH_IRQ_ENABLED: tk = ms[FLAG_I];
            OP_BRANCH_IRQ_DISABLED: tk = !ms[FLAG_I];
            OP_LOGICAL_LEFT_SHIFT: {c, r} = {v, 1'b0};
            OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, v};
            OP_ROTATE_LEFT_CARRY: {c, r} = {v, ms[FLAG_C]};
            OP_ROTATE_RIGHT_CARRY: {r, c} = {ms[FLAG_C], v};
            OP_ARITH_RIGHT_SHIFT: {r, c} = {v[7], v};
            OP_NIBBLE_SWAP: r = {v[3:0], v[7:4]};
            OP_FLAG_INDEX_SET: ms[b] = 1'b1;
            OP_FLAG_INDEX_CLEAR: ms[b] = 1'b0;
            OP_BIT_TO_TRANSFER_FLAG: ms[FLAG_T] = v[b];
            OP_TRANSFER_FLAG_TO_BIT: r[b] = ms[FLAG_T];
            default: ;
        endcase
        // Shifts own Z, C, N and V only
        if (op >= OP_LOGICAL_LEFT_SHIFT && op <= OP_ARITH_RIGHT_SHIFT) begin
            ms[FLAG_C] = c;
            ms[FLAG_Z] = (r == 8'h00);
            ms[FLAG_N] = r[7];
            ms[FLAG_V] = r[7] ^ c;
        end
        // Set/clear forms alternate
        if (op >= OP_CARRY_SET && op <= OP_SIGN_FLAG_CLEAR) begin
            f = op - OP_CARRY_SET;
            ms[fl[f / 2]] = !f[0];
        end
        @(posedge clk_sys);
        opValid <= 1'b1;
        opCode <= op;
        opBitSel <= b;
        opOffset <= k;
        pcIn <= pc;
        opIoAddr <= v[5:0];
        opRegAddr <= v[4:0];
        opRegValue <= v;
        @(posedge clk_sys);
        opValid <= 1'b0;
        ioRdData <= iv;
        opCount++;
        if (wr) begin
            lr = r;
        end
        #1;
        chk("statusOut", statusOut, ms);
        chk("pcLoad", pcLoad, tk);
        chk("pcTarget", tk ? pcTarget : tgt, tgt);
        chk("opReady", opReady, !(tk || io));
        chk("regWrEn", regWrEn, wr);
        chk("regWrData", wr ? regWrData : r, r);
        chk("regWrAddr", wr ? regWrAddr : v[4:0], v[4:0]);
        chk("ioRdEn", ioRdEn, io);
        if (io) begin
            chk("ioAddr", ioAddr, v[5:0]);
            @(posedge clk_sys);
            #1;
            chk("ioWrEn", ioWrEn, 1'b1);
            chk("ioWrData", ioWrData, op == OP_IO_BIT_SET ? iv | m : iv & ~m);
            chk("statusOut", statusOut, ms);
        end
    endtask : ex

    // Main sequence
    initial begin
        int i;
        int j;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        br(REG_STATUS, STATUS_RESET);
        br(REG_ENGINE_STATE, 8'h01);
        br(4'hF, 8'h00);
        bw(REG_LAST_RESULT, 8'hFF);
        br(REG_LAST_RESULT, RESULT_RESET);
        // Each V and I pair under each branch, other bits random
        for (i = 0; i < 8; i++) begin
            j = ($random(seed) & 8'h77) | {i[1], 3'h0, i[0], 3'h0};
            bw(REG_STATUS, j[7:0]);
            ex(OP_BRANCH_OVERFLOW_CLEAR);
            ex(OP_BRANCH_IRQ_ENABLED);
            ex(OP_BRANCH_IRQ_DISABLED);
        end
        for (i = OP_IO_BIT_SET; i <= OP_SIGN_FLAG_CLEAR; i++) begin
            ex(i[4:0]);
        end
        repeat (200) begin
            j = $unsigned($random(seed)) % 25;
            ex(j[4:0]);
        end
        ex(5'h1F);
        br(REG_OP_COUNT, opCount[7:0]);
        br(REG_LAST_RESULT, lr);
        br(REG_STATUS, ms);
        close_out();
    end
endmodule : tb
`default_nettype wire
